/* core/fobe_ctrl.sv */
/*
 On-board flash erase checking, mode decode at reset and boot-mode serial
 entry with automatic bit rate measurement.
 Assumes all inputs are synchronous to ref_clk and that the flash array
 answers an erase strobe with one erase_ack pulse.
*/
`timescale 1ns/1ps
module fobe_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Mode pins, sampled after reset release
  input wire logic write_enable_pin,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic nmi_pin,
  // Erase request from the CPU side
  input wire logic erase_req,
  input wire logic [31:0] erase_block_select_param,
  input wire logic [7:0] array_select,
  input wire logic [7:0] flash_key,
  input wire logic error_protect_latch,
  input wire logic ctrl_reg_changed,
  // Flash array handshake
  input wire logic erase_ack,
  input wire logic erase_fail,
  // Programming completion
  input wire logic prog_end,
  input wire logic prog_abnormal,
  // Boot program user side
  input wire logic inquiry_done,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  // Serial line
  input wire logic serial_rx,
  // Erase and programming results, and erase commands to the array
  output logic erase_done,
  output logic [7:0] erase_result_flags,
  output logic [7:0] prog_result_flags,
  output logic erase_start,
  output logic [3:0] erase_block,
  output logic erase_all,
  // Mode status
  output logic onboard_mode,
  output logic boot_mode,
  output logic user_boot_mode,
  output logic user_prog_mode,
  output logic irq_ignored,
  output logic boot_ready,
  // Serial data to and from the boot program
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_strobe,
  output logic serial_tx,
  output logic [15:0] baud_div
);
  import fobe_pkg::*;

  function automatic logic [15:0] fobe_rate(input logic [19:0] low_clks);
    logic [19:0] q;
    q = (low_clks + `FOBE_ROUND) / `FOBE_LOW_BITS;
    if (q == 20'h0_0000) begin
      q = 20'h0_0001;
    end
    fobe_rate = q[15:0];
  endfunction

  fobe_boot_st_t boot_st_q;
  fobe_erase_st_t er_st_q;
  logic latched_q;
  logic [19:0] meas_cnt_q;
  logic [7:0] flags_q;
  logic ctrl_seen_q;
  logic all_pending_q;
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic tx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_shift_q;
  logic [7:0] buf_mem_q [0:1];
  logic buf_wr_q;
  logic buf_rd_q;
  logic [1:0] buf_cnt_q;
  logic [1:0] buf_cnt_d;
  logic buf_push;
  logic buf_pop;
  logic [7:0] buf_in;
  logic serial_on;

  // Mode pins caught once, on the first edge after release
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      latched_q <= 1'b0;
      onboard_mode <= 1'b0;
      boot_mode <= 1'b0;
      user_boot_mode <= 1'b0;
      user_prog_mode <= 1'b0;
      irq_ignored <= 1'b0;
    end else if (!latched_q) begin
      latched_q <= 1'b1;
      onboard_mode <= write_enable_pin & (mode_select_hi == mode_select_lo);
      boot_mode <= write_enable_pin & !mode_select_hi & !mode_select_lo & nmi_pin;
      user_boot_mode <= write_enable_pin & !mode_select_hi & !mode_select_lo & !nmi_pin;
      user_prog_mode <= write_enable_pin & mode_select_hi & mode_select_lo;
      // Interrupts stay blocked while the boot program owns the port
      irq_ignored <= write_enable_pin & !mode_select_hi & !mode_select_lo & nmi_pin;
    end
  end

  // Boot entry sequence
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      boot_st_q <= FOBE_BT_IDLE;
      meas_cnt_q <= 20'h0_0000;
      baud_div <= 16'h0001;
      erase_all <= 1'b0;
      all_pending_q <= 1'b0;
      boot_ready <= 1'b0;
    end else begin
      erase_all <= 1'b0;
      case (boot_st_q)
        FOBE_BT_IDLE: begin
          if (latched_q && boot_mode) begin
            boot_st_q <= FOBE_BT_MEASURE;
          end
        end
        FOBE_BT_MEASURE: begin
          // Start bit plus eight zero data bits form one low stretch
          if (!serial_rx) begin
            // Wide enough for the slowest host rate at the fastest system clock
            if (meas_cnt_q != `FOBE_MEAS_MAX) begin
              meas_cnt_q <= meas_cnt_q + 20'h0_0001;
            end
          end else if (meas_cnt_q != 20'h0_0000) begin
            baud_div <= fobe_rate(meas_cnt_q);
            boot_st_q <= FOBE_BT_SEND_ACK;
          end
        end
        FOBE_BT_SEND_ACK: begin
          if (buf_cnt_q != `FOBE_BUF_DEPTH) begin
            boot_st_q <= FOBE_BT_WAIT_SYNC;
          end
        end
        FOBE_BT_WAIT_SYNC: begin
          // Further zero bytes from the host are simply dropped here
          if (rx_strobe && rx_data == `FOBE_SYNC_BYTE) begin
            boot_st_q <= FOBE_BT_INQUIRY;
            boot_ready <= 1'b1;
          end
        end
        FOBE_BT_INQUIRY: begin
          if (inquiry_done) begin
            boot_st_q <= FOBE_BT_ERASE_ALL;
            erase_all <= 1'b1;
            all_pending_q <= 1'b1;
          end
        end
        FOBE_BT_ERASE_ALL: begin
          if (erase_ack) begin
            all_pending_q <= 1'b0;
            boot_st_q <= FOBE_BT_CMD_WAIT;
          end
        end
        FOBE_BT_CMD_WAIT: begin
          boot_st_q <= FOBE_BT_CMD_WAIT;
        end
        default: begin
          boot_st_q <= FOBE_BT_IDLE;
        end
      endcase
    end
  end

  // Block erase checking
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      er_st_q <= FOBE_ER_IDLE;
      flags_q <= 8'h00;
      ctrl_seen_q <= 1'b0;
      erase_done <= 1'b0;
      erase_start <= 1'b0;
      erase_block <= 4'h0;
      erase_result_flags <= 8'h00;
    end else begin
      erase_done <= 1'b0;
      erase_start <= 1'b0;
      case (er_st_q)
        FOBE_ER_IDLE: begin
          // Whole-array erase owns the array until it is acknowledged
          if (erase_req && !all_pending_q) begin
            er_st_q <= FOBE_ER_CHECK;
            ctrl_seen_q <= 1'b0;
            flags_q <= 8'h00;
            flags_q[`FOBE_BIT_MD] <= !write_enable_pin | error_protect_latch |
                                     !onboard_mode;
            flags_q[`FOBE_BIT_FK] <= flash_key != `FOBE_KEY_OK;
            // Any upper bit set also lands outside the array
            flags_q[`FOBE_BIT_EB] <= erase_block_select_param > `FOBE_BLK_LAST;
            flags_q[`FOBE_BIT_EE] <= array_select == `FOBE_ARR_BOOT;
            erase_block <= erase_block_select_param[3:0];
          end
        end
        FOBE_ER_CHECK: begin
          if (flags_q != 8'h00) begin
            er_st_q <= FOBE_ER_DONE;
          end else begin
            erase_start <= 1'b1;
            er_st_q <= FOBE_ER_WAIT;
          end
        end
        FOBE_ER_WAIT: begin
          if (ctrl_reg_changed) begin
            ctrl_seen_q <= 1'b1;
          end
          if (erase_ack) begin
            flags_q[`FOBE_BIT_EE] <= erase_fail | ctrl_seen_q | ctrl_reg_changed;
            er_st_q <= FOBE_ER_DONE;
          end
        end
        FOBE_ER_DONE: begin
          erase_result_flags <= flags_q;
          erase_result_flags[`FOBE_BIT_SF] <= flags_q != 8'h00;
          erase_done <= 1'b1;
          er_st_q <= FOBE_ER_IDLE;
        end
        default: begin
          er_st_q <= FOBE_ER_IDLE;
        end
      endcase
    end
  end

  // Programming completion status
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prog_result_flags <= 8'h00;
    end else if (prog_end) begin
      prog_result_flags <= 8'h00;
      prog_result_flags[`FOBE_BIT_SF] <= prog_abnormal;
    end
  end

  // Serial receiver, active once the rate is known
  assign serial_on = boot_st_q != FOBE_BT_IDLE && boot_st_q != FOBE_BT_MEASURE;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_data <= 8'h00;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      if (!rx_busy_q) begin
        if (serial_on && !serial_rx) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= {1'b0, baud_div[15:1]};
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= baud_div - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          // A glitch shorter than half a bit is not a start bit
          rx_busy_q <= !serial_rx;
        end else if (rx_bit_q == `FOBE_FRAME_STOP) begin
          rx_busy_q <= 1'b0;
          if (serial_rx) begin
            rx_data <= rx_shift_q;
            rx_strobe <= 1'b1;
          end
        end else begin
          rx_shift_q <= {serial_rx, rx_shift_q[7:1]};
        end
      end
    end
  end

  // Two-entry transmit buffer; the confirmation byte goes in first
  assign buf_push = (boot_st_q == FOBE_BT_SEND_ACK) ? (buf_cnt_q != `FOBE_BUF_DEPTH) :
                    (boot_ready && tx_valid && tx_ready);
  assign buf_in = (boot_st_q == FOBE_BT_SEND_ACK) ? `FOBE_ACK_BYTE : tx_data;
  assign buf_pop = !tx_busy_q && buf_cnt_q != 2'h0;

  always_comb begin
    buf_cnt_d = buf_cnt_q;
    if (buf_push && !buf_pop) begin
      buf_cnt_d = buf_cnt_q + 2'h1;
    end else if (buf_pop && !buf_push) begin
      buf_cnt_d = buf_cnt_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= 2'h0;
      tx_ready <= 1'b0;
      buf_mem_q[0] <= 8'h00;
      buf_mem_q[1] <= 8'h00;
    end else begin
      buf_cnt_q <= buf_cnt_d;
      // Ready lags by one cycle, so it is computed from the next count
      tx_ready <= boot_ready && buf_cnt_d != `FOBE_BUF_DEPTH;
      if (buf_push) begin
        buf_mem_q[buf_wr_q] <= buf_in;
        buf_wr_q <= !buf_wr_q;
      end
      if (buf_pop) begin
        buf_rd_q <= !buf_rd_q;
      end
    end
  end

  // Serial transmitter, 8N1 at the measured divisor
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 10'h3FF;
      serial_tx <= 1'b1;
    end else if (!tx_busy_q) begin
      serial_tx <= 1'b1;
      if (buf_pop) begin
        tx_busy_q <= 1'b1;
        tx_shift_q <= {1'b1, buf_mem_q[buf_rd_q], 1'b0};
        tx_cnt_q <= 16'h0000;
        tx_bit_q <= 4'h0;
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else if (tx_bit_q == `FOBE_TX_BITS) begin
      tx_busy_q <= 1'b0;
      serial_tx <= 1'b1;
    end else begin
      serial_tx <= tx_shift_q[0];
      tx_shift_q <= {1'b1, tx_shift_q[9:1]};
      tx_cnt_q <= baud_div - 16'h0001;
      tx_bit_q <= tx_bit_q + 4'h1;
    end
  end
endmodule

/* core/fobe_defs.svh */
/*
 Constants of the on-board flash boot and erase controller.
 Assumes inclusion by its bare name from the package, which the controller imports.
*/
`ifndef FOBE_DEFS_SVH
`define FOBE_DEFS_SVH
`define FOBE_BLK_LAST 32'h0000_000B
`define FOBE_KEY_OK 8'h5A
`define FOBE_ARR_BOOT 8'hAA
`define FOBE_SYNC_BYTE 8'h55
`define FOBE_ACK_BYTE 8'h00
`define FOBE_BIT_MD 6
`define FOBE_BIT_EE 5
`define FOBE_BIT_FK 4
`define FOBE_BIT_EB 3
`define FOBE_BIT_SF 0
`define FOBE_LOW_BITS 20'h0_0009
`define FOBE_ROUND 20'h0_0004
`define FOBE_MEAS_MAX 20'hF_FFFF
`define FOBE_FRAME_STOP 4'h9
`define FOBE_TX_BITS 4'hA
`define FOBE_BUF_DEPTH 2'h2
`endif

/* core/fobe_pkg.sv */
/*
 Types of the on-board flash boot and erase controller.
 Assumes the constants header sits beside it.
*/
`include "fobe_defs.svh"
package fobe_pkg;
  typedef enum logic [2:0] {
    FOBE_BT_IDLE = 3'h0,
    FOBE_BT_MEASURE = 3'h1,
    FOBE_BT_SEND_ACK = 3'h3,
    FOBE_BT_WAIT_SYNC = 3'h2,
    FOBE_BT_INQUIRY = 3'h6,
    FOBE_BT_ERASE_ALL = 3'h7,
    FOBE_BT_CMD_WAIT = 3'h5
  } fobe_boot_st_t;
  typedef enum logic [1:0] {
    FOBE_ER_IDLE = 2'h0,
    FOBE_ER_CHECK = 2'h1,
    FOBE_ER_WAIT = 2'h3,
    FOBE_ER_DONE = 2'h2
  } fobe_erase_st_t;
endpackage

/* testbench/fobe_ctrl_assertions.sv */
/*
 Port checks of the boot and erase controller.
 Assumes one domain, ref_clk, with synchronous active-low reset_n.
*/
`timescale 1ns/1ps
module fobe_ctrl_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Watched inputs
  input wire logic [31:0] erase_block_select_param,
  input wire logic [7:0] array_select,
  input wire logic [7:0] flash_key,
  input wire logic erase_ack,
  input wire logic erase_fail,
  input wire logic prog_end,
  input wire logic prog_abnormal,
  // Watched outputs
  input wire logic erase_done,
  input wire logic [7:0] erase_result_flags,
  input wire logic [7:0] prog_result_flags,
  input wire logic erase_start,
  input wire logic onboard_mode,
  input wire logic boot_mode,
  input wire logic user_boot_mode,
  input wire logic user_prog_mode,
  input wire logic irq_ignored,
  input wire logic boot_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_strobe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Whole-array acks carry no result, so only block erases are tracked
  logic blk_busy_q;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      blk_busy_q <= 1'b0;
    end else if (erase_start) begin
      blk_busy_q <= 1'b1;
    end else if (erase_done) begin
      blk_busy_q <= 1'b0;
    end
  end
  sequence s_fail_ack;
    erase_ack && erase_fail && blk_busy_q;
  endsequence
  sequence s_fail_seen;
    ##2 erase_done && erase_result_flags[5];
  endsequence
  AST_FAIL_FLAG: assert property (s_fail_ack |-> s_fail_seen)
    else $error("array failure not reported");
  AST_START_KEY: assert property (erase_start |-> $past(flash_key, 2) == 8'h5A)
    else $error("erase started with bad key");
  AST_START_RANGE: assert property (
    erase_start |-> $past(erase_block_select_param, 2) <= 32'h0000_000B)
    else $error("erase started out of range");
  AST_START_ARRAY: assert property (erase_start |-> $past(array_select, 2) != 8'hAA)
    else $error("erase started on boot array");
  AST_SF_ANY: assert property (
    erase_done |-> erase_result_flags[0] == (|erase_result_flags[6:3]))
    else $error("fail bit disagrees with flags");
  AST_PROG_FLAG: assert property (
    prog_end |=> prog_result_flags[0] == $past(prog_abnormal))
    else $error("program result wrong");
  AST_MODE_ONE: assert property (
    onboard_mode == $onehot({boot_mode, user_boot_mode, user_prog_mode}))
    else $error("mode outputs inconsistent");
  AST_IRQ_IGN: assert property (irq_ignored == boot_mode)
    else $error("interrupt ignore wrong");
  AST_READY_HOLDS: assert property (boot_ready |=> boot_ready)
    else $error("boot ready dropped");
  AST_SYNC_SEEN: assert property (
    $rose(boot_ready) |-> $past(rx_strobe) && $past(rx_data) == 8'h55)
    else $error("boot ready without sync byte");
endmodule
bind fobe_ctrl fobe_ctrl_checker chk (.ref_clk, .reset_n, .erase_block_select_param,
  .array_select, .flash_key, .erase_ack, .erase_fail, .prog_end, .prog_abnormal,
  .erase_done, .erase_result_flags, .prog_result_flags, .erase_start, .onboard_mode,
  .boot_mode, .user_boot_mode, .user_prog_mode, .irq_ignored, .boot_ready, .rx_data,
  .rx_strobe);

/* testbench/fobe_ctrl_tb_top.sv */
/*
 Self-checking bench of the boot and erase controller.
 Assumes the host model on the serial pins; the bench plays CPU and array.
*/
`timescale 1ns/1ps
module fobe_ctrl_tb_top;
  localparam int BIT = 40;
  logic ref_clk, reset_n, write_enable_pin, mode_select_hi, mode_select_lo, nmi_pin;
  logic erase_req, error_protect_latch, ctrl_reg_changed, erase_ack, erase_fail;
  logic prog_end, prog_abnormal, inquiry_done, tx_valid, serial_rx, serial_tx;
  logic [31:0] erase_block_select_param;
  logic [7:0] array_select, flash_key, tx_data, rx_data, erase_result_flags;
  logic [7:0] prog_result_flags;
  logic erase_done, erase_start, erase_all, onboard_mode, boot_mode, user_boot_mode;
  logic user_prog_mode, irq_ignored, boot_ready, tx_ready, rx_strobe, onb;
  logic [3:0] erase_block;
  logic [15:0] baud_div;
  logic [7:0] exp_q[$];
  int failures = 0;
  int checks_done = 0;
  fobe_ctrl dut (.ref_clk, .reset_n, .write_enable_pin, .mode_select_hi, .mode_select_lo,
    .nmi_pin, .erase_req, .erase_block_select_param, .array_select, .flash_key,
    .error_protect_latch, .ctrl_reg_changed, .erase_ack, .erase_fail, .prog_end,
    .prog_abnormal, .inquiry_done, .tx_data, .tx_valid, .serial_rx, .erase_done,
    .erase_result_flags, .prog_result_flags, .erase_start, .erase_block, .erase_all,
    .onboard_mode, .boot_mode, .user_boot_mode, .user_prog_mode, .irq_ignored,
    .boot_ready, .tx_ready, .rx_data, .rx_strobe, .serial_tx, .baud_div);
  fobe_host_model #(.BIT(BIT)) host (.ref_clk, .serial_tx, .serial_rx);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A host that misses the confirmation restarts through this reset
  task automatic do_reset(input logic [3:0] pins);
    {write_enable_pin, mode_select_hi, mode_select_lo, nmi_pin} <= pins;
    reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic do_erase(input logic [31:0] blk, input logic [7:0] key, arr,
                          input logic prot, chg, fail);
    logic md, fk, eb, ee, pre;
    md = prot | !onb;
    fk = key != 8'h5A;
    eb = blk > 32'h0000_000B;
    pre = md | fk | eb | (arr == 8'hAA);
    ee = (arr == 8'hAA) | (!pre & (chg | fail));
    exp_q.push_back({1'b0, md, ee, fk, eb, 2'b00, md | fk | eb | ee});
    erase_req <= 1'b1;
    erase_block_select_param <= blk;
    flash_key <= key;
    array_select <= arr;
    error_protect_latch <= prot;
    @(posedge ref_clk);
    erase_req <= 1'b0;
    if (!pre) begin
      repeat (8) begin
        @(posedge ref_clk);
        if (erase_start === 1'b1) break;
      end
      cmp("erase_start", {11'h0, 1'b1, blk[3:0]}, {11'h0, erase_start, erase_block});
      ctrl_reg_changed <= chg;
      @(posedge ref_clk);
      ctrl_reg_changed <= 1'b0;
      erase_ack <= 1'b1;
      erase_fail <= fail;
      @(posedge ref_clk);
      erase_ack <= 1'b0;
      erase_fail <= 1'b0;
    end
    repeat (10) begin
      @(posedge ref_clk);
      if (erase_done === 1'b1) break;
    end
    @(posedge ref_clk);
  endtask
  // Result watcher: each done pulse takes the oldest expectation
  always @(posedge ref_clk) begin
    if (erase_done === 1'b1) begin
      if (exp_q.size() == 0) cmp("erase_result_flags", 16'hFFFF, 16'h0000);
      else cmp("erase_result_flags", {8'h0, exp_q.pop_front()}, {8'h0, erase_result_flags});
    end
  end
  initial begin
    #400_000;
    failures++;
    conclude();
  end
  initial begin
    logic [7:0] b;
    logic [7:0] tbl [6];
    tbl = '{8'h10, 8'hB0, 8'h8A, 8'hE9, 8'hF9, 8'h9C};
    reset_n = 1'b0;
    {erase_req, error_protect_latch, ctrl_reg_changed, erase_ack, erase_fail} = 5'h00;
    {prog_end, prog_abnormal, inquiry_done, tx_valid} = 4'h0;
    erase_block_select_param = 32'h0000_0000;
    {array_select, flash_key, tx_data} = 24'h00_0000;
    void'($urandom(49067));
    foreach (tbl[i]) begin
      do_reset(tbl[i][7:4]);
      onb = tbl[i][3];
      cmp("mode_outputs", {11'h0, tbl[i][3:0], tbl[i][2]}, {11'h0, onboard_mode, boot_mode,
        user_boot_mode, user_prog_mode, irq_ignored});
      if (!onb) do_erase(32'h0000_0000, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0);
    end
    fork
      begin
        host.send_byte(8'h00);
        host.send_byte(8'h00);
      end
      host.recv_byte(b);
    join
    cmp("ack_byte", 16'h0000, {8'h0, b});
    cmp("baud_div", 16'(BIT), baud_div);
    host.send_byte(8'h55);
    repeat (2) @(posedge ref_clk);
    cmp("boot_ready", 16'h0001, {15'h0, boot_ready});
    tx_data <= 8'hA5;
    tx_valid <= 1'b1;
    fork
      begin
        repeat (20) begin
          @(posedge ref_clk);
          if (tx_ready === 1'b1) break;
        end
        tx_valid <= 1'b0;
      end
      host.recv_byte(b);
    join
    cmp("tx_byte", 16'h00A5, {8'h0, b});
    inquiry_done <= 1'b1;
    @(posedge ref_clk);
    inquiry_done <= 1'b0;
    repeat (20) begin
      @(posedge ref_clk);
      if (erase_all === 1'b1) break;
    end
    cmp("erase_all", 16'h0001, {15'h0, erase_all});
    erase_ack <= 1'b1;
    @(posedge ref_clk);
    erase_ack <= 1'b0;
    repeat (3) @(posedge ref_clk);
    do_erase(32'h0000_0000, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_000B, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_000C, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_0100, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_0003, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_0003, 8'h5A, 8'hAA, 1'b0, 1'b0, 1'b0);
    do_erase(32'h0000_0003, 8'h5A, 8'h00, 1'b1, 1'b0, 1'b0);
    do_erase(32'h0000_0005, 8'h5A, 8'h00, 1'b0, 1'b1, 1'b0);
    do_erase(32'h0000_0007, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b1);
    repeat (6) do_erase(32'($urandom_range(0, 13)), $urandom_range(0, 1) ? 8'h5A : 8'($urandom),
      8'h00, 1'b0, 1'($urandom), 1'($urandom));
    for (int i = 0; i < 3; i++) begin
      prog_abnormal <= 1'(i);
      prog_end <= 1'b1;
      @(posedge ref_clk);
      prog_end <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp("prog_result", {15'h0, 1'(i)}, {15'h0, prog_result_flags[0]});
    end
    conclude();
  end
endmodule

/* testbench/fobe_host_model.sv */
/*
 Host tool model on the serial link, 8N1, least significant bit first.
 Assumes BIT is the bit time in ref_clk cycles, scaled down to keep runs short.
*/
`timescale 1ns/1ps
module fobe_host_model #(
  parameter int BIT = 40
) (
  // Clock
  input wire logic ref_clk,
  // Serial line
  input wire logic serial_tx,
  output logic serial_rx
);
  initial serial_rx = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx <= fr[i];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
  // Bounded wait, so a silent device shows up as a bad byte
  task automatic recv_byte(output logic [7:0] b);
    int n;
    b = 8'hxx;
    n = 0;
    while (serial_tx !== 1'b0 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        b[i] = serial_tx;
      end
    end
  endtask
endmodule
